/* File: design/pur_sequencer.sv */
// Power-up reset sequencer: power-on sense, PLL release, settle wait,
// processor release, domain defaults, low power handling, power-fail park.
// Assumes all inputs synchronous to the 10 MHz reference clock.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Low power-on sense holds full system reset
// - Outputs high impedance while sense low
// - Sense rising edge releases only primary PLL
// - Rest stays in reset 60 ms more
// - After wait, release processor resets
// - Default normal mode, processor clocks full rate
// - Other clocks disabled, in reset until released
// - Power gating defaults to all on
// - Same defaults on every reset except LVDS
// - Low-power entry keeps LVDS off until boot
// - Boot, then 1.8V, clocks, DRAM order
// - Power-fail warning parks mirrors then resets
module pur_sequencer
   import pur_pkg::*;
#(
   parameter int unsigned SETTLE_CNT = SETTLE_CYCLES,
   parameter int unsigned N_DOM      = 4
) (
   // Clock and reset
   input  wire logic             i_ref_clk,
   input  wire logic             i_rst_b,
   // Supply monitor
   input  wire logic             i_power_on_sense,
   input  wire logic             i_power_fail_warning,
   // Other reset sources and processor requests
   input  wire logic             i_wdog_rst,
   input  wire logic             i_low_power_req,
   input  wire logic             i_sys_init_done,
   input  wire logic             i_lvds_pwr_on_req,
   input  wire logic [N_DOM-1:0] i_dom_release,
   input  wire logic             i_dram_init_req,
   input  wire logic             i_mirror_parked,
   // Outputs
   output logic                  o_pad_oe,
   output logic                  o_primary_pll_rst_b,
   output logic                  o_cpu_rst_b,
   output logic                  o_cpu_clk_en,
   output logic                  o_cpu_full_rate,
   output pur_dom_t [N_DOM-1:0]  o_dom,
   output logic                  o_pwr_gate_en,
   output logic                  o_lvds_pwr_en,
   output logic                  o_dram_init,
   output logic                  o_mirror_park,
   output logic                  o_sys_rst
);

   // ----------------------------------------------------------------
   // Sequencing state
   // ----------------------------------------------------------------
   pur_state_t        state;
   pur_state_t        next_state;
   logic [CNT_W-1:0]  cnt;
   logic              sense_q;
   logic              low_power;
   logic              dom_rst;

   localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CNT - 1);
   localparam logic [CNT_W-1:0] PARK_LAST   = CNT_W'(PARK_CYCLES - 1);

   always_comb begin
      next_state = state;
      case (state)
         PUR_OFF: begin
            if (i_power_on_sense && !sense_q) next_state = PUR_SETTLE;
         end
         PUR_SETTLE: begin
            if (!i_power_on_sense) next_state = PUR_OFF;
            else if (cnt == SETTLE_LAST) next_state = PUR_RUN;
         end
         PUR_RUN: begin
            if (!i_power_on_sense) next_state = PUR_OFF;
            else if (i_power_fail_warning) next_state = PUR_PARK;
            else if (i_wdog_rst) next_state = PUR_HOLD;
         end
         PUR_PARK: begin
            if (!i_power_on_sense) next_state = PUR_OFF;
            else if (i_mirror_parked || cnt == PARK_LAST) next_state = PUR_HOLD;
         end
         PUR_HOLD: begin
            // Warm reset replays the settle wait with the PLL kept running
            if (!i_power_on_sense) next_state = PUR_OFF;
            else if (!i_power_fail_warning) next_state = PUR_SETTLE;
         end
         default: next_state = PUR_OFF;
      endcase
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state   <= PUR_OFF;
         sense_q <= 1'b1;   // Sense already high at release is no edge
      end else begin
         state   <= next_state;
         sense_q <= i_power_on_sense;
      end
   end

   // Counter restarts on any state change, so a sense drop restarts the wait
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cnt <= '0;
      end else if (next_state != state) begin
         cnt <= '0;
      end else if (state == PUR_SETTLE || state == PUR_PARK) begin
         cnt <= cnt + CNT_W'(1);
      end
   end

   // ----------------------------------------------------------------
   // Reset and clock outputs
   // ----------------------------------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_pad_oe            <= 1'b0;
         o_primary_pll_rst_b <= 1'b0;
         o_cpu_rst_b         <= 1'b0;
         o_cpu_clk_en        <= 1'b0;
         o_cpu_full_rate     <= 1'b0;
         o_sys_rst           <= 1'b1;
         o_mirror_park       <= 1'b0;
      end else begin
         o_pad_oe            <= (next_state != PUR_OFF);
         o_primary_pll_rst_b <= (next_state != PUR_OFF);
         o_cpu_rst_b         <= (next_state == PUR_RUN) ||
                                (next_state == PUR_PARK);
         o_cpu_clk_en        <= (next_state == PUR_RUN) ||
                                (next_state == PUR_PARK);
         o_cpu_full_rate     <= (next_state == PUR_RUN) ||
                                (next_state == PUR_PARK);
         o_sys_rst           <= (next_state != PUR_RUN) &&
                                (next_state != PUR_PARK);
         o_mirror_park       <= (next_state == PUR_PARK);
      end
   end

   assign dom_rst = o_sys_rst;

   // ----------------------------------------------------------------
   // Domains outside the processor
   // ----------------------------------------------------------------
   for (genvar g = 0; g < N_DOM; g++) begin : g_dom
      pur_domain_ctl u_dom (
         .i_ref_clk (i_ref_clk),
         .i_rst_b   (i_rst_b),
         .i_sys_rst (dom_rst),
         .i_release (i_dom_release[g] && o_lvds_pwr_en),
         .o_dom     (o_dom[g])
      );
   end

   // ----------------------------------------------------------------
   // Power gating and the LVDS/DRAM 1.8V domain
   // ----------------------------------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_pwr_gate_en <= 1'b0;
      end else begin
         o_pwr_gate_en <= GATE_ALL_ON && (state != PUR_OFF);
      end
   end

   // Low power mode survives a warm reset but not a power-on sense drop
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         low_power <= 1'b0;
      end else if (state == PUR_OFF) begin
         low_power <= 1'b0;
      end else if (i_low_power_req && state == PUR_RUN) begin
         low_power <= 1'b1;
      end else if (i_sys_init_done && i_lvds_pwr_on_req && o_cpu_rst_b) begin
         low_power <= 1'b0;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_lvds_pwr_en <= LVDS_PWR_OFF;
      end else if (state == PUR_OFF || low_power) begin
         o_lvds_pwr_en <= LVDS_PWR_OFF;
      end else if (i_lvds_pwr_on_req && o_cpu_rst_b) begin
         o_lvds_pwr_en <= 1'b1;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_dram_init <= 1'b0;
      end else begin
         o_dram_init <= i_dram_init_req && o_lvds_pwr_en && o_cpu_rst_b &&
                        (|o_dom[0].clk_en);
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   // Cycles since PLL release with the processor held; saturates so a long hold cannot wrap
   logic [CNT_W-1:0] rel_age;

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rel_age <= '0;
      end else if (!o_primary_pll_rst_b || o_cpu_rst_b) begin
         rel_age <= '0;
      end else if (rel_age != '1) begin
         rel_age <= rel_age + CNT_W'(1);
      end
   end

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_b);

   low_holds_a: assert property (!i_power_on_sense |=> o_sys_rst && !o_cpu_rst_b)
      else $error("reset not held with sense low");
   hiz_low_a: assert property (!i_power_on_sense |=> !o_pad_oe)
      else $error("pads driven with sense low");
   pll_first_a: assert property ($rose(o_primary_pll_rst_b) |-> !o_cpu_rst_b)
      else $error("cpu released with pll");
   settle_wait_a: assert property ($rose(o_primary_pll_rst_b) |-> !o_cpu_rst_b [*8])
      else $error("settle wait too short");
   cpu_rel_a: assert property ($rose(o_cpu_rst_b) |-> o_cpu_clk_en && o_cpu_full_rate)
      else $error("cpu released without clock");
   dom_hold_a: assert property (o_sys_rst |=> !o_dom[0].clk_en && !o_dom[0].rst_b)
      else $error("domain enabled in reset");
   gate_on_a: assert property (o_cpu_rst_b |-> o_pwr_gate_en)
      else $error("power gating not all on");
   lvds_low_a: assert property (low_power |=> !o_lvds_pwr_en)
      else $error("lvds on in low power");
   park_then_a: assert property ($rose(o_mirror_park) |-> !o_sys_rst ##1 o_mirror_park)
      else $error("reset before park");
   restart_a: assert property (state == PUR_SETTLE && !i_power_on_sense |=> cnt == '0)
      else $error("wait count not restarted");
   wait_len_a: assert property ($rose(o_cpu_rst_b) |-> rel_age >= CNT_W'(SETTLE_CNT))
      else $error("processor released before settle count");

   boot_c:  cover property ($rose(o_cpu_rst_b));
   park_c:  cover property ($rose(o_mirror_park));
   warm_c:  cover property (state == PUR_HOLD ##1 state == PUR_SETTLE);
   lvds_c:  cover property ($rose(o_lvds_pwr_en));

endmodule
`default_nettype wire

/* File: design/pur_pkg.sv */
// Package for the power-up reset sequencer: timing counts, states, carriers.
// Assumes a single 10 MHz reference clock.
package pur_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int unsigned REF_CLK_HZ     = 10_000_000;
   localparam int unsigned SETTLE_MS      = 60;
   localparam int unsigned SETTLE_CYCLES  = REF_CLK_HZ / 1000 * SETTLE_MS;
   localparam int unsigned PARK_CYCLES    = 16;
   localparam int unsigned CNT_W          = 20;

   // ----------------------------------------------------------------
   // Reset defaults
   // ----------------------------------------------------------------
   localparam logic        GATE_ALL_ON    = 1'b1;
   localparam logic        LVDS_PWR_OFF   = 1'b0;

   // ----------------------------------------------------------------
   // States, Gray coded along the power-up path
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      PUR_OFF    = 3'b000,
      PUR_SETTLE = 3'b001,
      PUR_RUN    = 3'b011,
      PUR_PARK   = 3'b010,
      PUR_HOLD   = 3'b110
   } pur_state_t;

   // Per-domain clock enable and reset request
   typedef struct packed {
      logic clk_en;
      logic rst_b;
   } pur_dom_t;

endpackage

/* File: design/pur_domain_ctl.sv */
// Clock enable and reset holder for one domain outside the processor.
// Assumes the processor release strobe is a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
module pur_domain_ctl
   import pur_pkg::*;
(
   // Clock and reset
   input  wire logic i_ref_clk,
   input  wire logic i_rst_b,
   // Control
   input  wire logic i_sys_rst,
   input  wire logic i_release,
   // Domain
   output pur_dom_t  o_dom
);

   // Disabled and held in reset until the processor releases it
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_dom <= '{clk_en: 1'b0, rst_b: 1'b0};
      end else if (i_sys_rst) begin
         o_dom <= '{clk_en: 1'b0, rst_b: 1'b0};
      end else if (i_release) begin
         o_dom <= '{clk_en: 1'b1, rst_b: 1'b1};
      end
   end

endmodule
`default_nettype wire

/* File: dv/pur_supply_mon.sv */
// Model of the external supply monitor that feeds the sequencer.
// Assumes the bench moves its supply and droop requests just after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module pur_supply_mon #(
   parameter int unsigned UP_DLY = 3
) (
   // Clock
   input  wire logic i_ref_clk,
   // Supply state from the bench
   input  wire logic i_supplies_up,
   input  wire logic i_droop_soon,
   // Monitor outputs
   output var logic  o_power_on_sense,
   output var logic  o_power_fail_warning
);
   // ---------------------------------------------------------------
   // Sense and warning
   // ---------------------------------------------------------------
   int unsigned up_cnt;
   initial begin
      up_cnt = 0;
      o_power_on_sense = 1'b0;
      o_power_fail_warning = 1'b0;
   end
   // Sense waits for the supplies to have settled a few cycles
   always @(posedge i_ref_clk) begin
      if (!i_supplies_up) begin
         up_cnt <= 0;
         o_power_on_sense <= 1'b0;
      end else if (up_cnt >= UP_DLY) begin
         o_power_on_sense <= 1'b1;
      end else begin
         up_cnt <= up_cnt + 1;
      end
      o_power_fail_warning <= i_droop_soon;
   end
endmodule
`default_nettype wire

/* File: dv/test_pur_sequencer.sv */
// Self-checking bench for the power-up reset sequencer.
// Assumes a short settle count in simulation and the supply monitor model.
`timescale 1ns/1ps
`default_nettype none
module test_pur_sequencer;
   import pur_pkg::*;
   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   localparam int unsigned SC = 20;
   logic i_ref_clk = 1'b0, i_rst_b = 1'b0, sup_up = 1'b0, droop = 1'b0;
   logic wdog = 1'b0, lp = 1'b0, init_done = 1'b0, lvds_req = 1'b0;
   logic dram_req = 1'b0, parked = 1'b0;
   logic [3:0] rel = 4'h0;
   logic sense, warn, pad_oe, pll_rst_b, cpu_rst_b, cpu_clk_en, full_rate;
   logic gate_en, lvds_en, dram_init, park, sys_rst;
   pur_dom_t [3:0] dom;
   int bad_count = 0;
   int num_checks = 0;
   int n;
   always #50 i_ref_clk = ~i_ref_clk;
   pur_supply_mon pur_supply_mon_i (.i_ref_clk(i_ref_clk), .i_supplies_up(sup_up),
      .i_droop_soon(droop), .o_power_on_sense(sense), .o_power_fail_warning(warn));
   pur_sequencer #(.SETTLE_CNT(SC), .N_DOM(4)) pur_sequencer_i (.i_ref_clk(i_ref_clk),
      .i_rst_b(i_rst_b), .i_power_on_sense(sense), .i_power_fail_warning(warn),
      .i_wdog_rst(wdog), .i_low_power_req(lp), .i_sys_init_done(init_done),
      .i_lvds_pwr_on_req(lvds_req), .i_dom_release(rel), .i_dram_init_req(dram_req),
      .i_mirror_parked(parked), .o_pad_oe(pad_oe), .o_primary_pll_rst_b(pll_rst_b),
      .o_cpu_rst_b(cpu_rst_b), .o_cpu_clk_en(cpu_clk_en), .o_cpu_full_rate(full_rate),
      .o_dom(dom), .o_pwr_gate_en(gate_en), .o_lvds_pwr_en(lvds_en),
      .o_dram_init(dram_init), .o_mirror_park(park), .o_sys_rst(sys_rst));
   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   // Same small delay after the last edge of every tick keeps drive and sample race free
   task automatic tick(input int k);
      repeat (k) @(posedge i_ref_clk);
      #10;
   endtask
   task automatic chk(input logic got, input logic exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t unexpected output value", $time);
      end
   endtask
   // Bounded wait for the PLL (0) or processor (1) reset release
   task automatic wait_for(input int which, output int k);
      k = 0;
      while (((which != 0) ? cpu_rst_b : pll_rst_b) !== 1'b1 && k < 200) begin
         tick(1);
         k++;
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d errors %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_off;
      tick(4);
      chk(sys_rst, 1'b1);
      chk(pad_oe, 1'b0);
      chk(pll_rst_b, 1'b0);
      chk(cpu_rst_b, 1'b0);
   endtask
   // Sense drops mid-wait, then a clean power-up
   task automatic t_power_up;
      sup_up = 1'b1;
      wait_for(0, n);
      chk(cpu_rst_b, 1'b0);
      chk(pad_oe, 1'b1);
      tick(SC / 2);
      sup_up = 1'b0;
      tick(3);
      chk(pll_rst_b, 1'b0);
      chk(cpu_rst_b, 1'b0);
      sup_up = 1'b1;
      wait_for(0, n);
      wait_for(1, n);
      chk(n >= SC - 2 && n <= SC + 2, 1'b1);
      chk(cpu_clk_en & full_rate, 1'b1);
      chk(sys_rst, 1'b0);
      chk(dom === '0, 1'b1);
      chk(gate_en, 1'b1);
   endtask
   task automatic t_boot;
      rel = 4'hF;
      tick(2);
      chk(dom[0].clk_en, 1'b0);
      rel = 4'h0;
      lvds_req = 1'b1;
      tick(2);
      chk(lvds_en, 1'b1);
      lvds_req = 1'b0;
      rel = 4'h1;
      tick(2);
      rel = 4'h0;
      chk(dom[0].clk_en & dom[0].rst_b, 1'b1);
      chk(dom[1].clk_en, 1'b0);
      dram_req = 1'b1;
      tick(2);
      chk(dram_init, 1'b1);
      dram_req = 1'b0;
   endtask
   // Low power entry, then a watchdog reset
   task automatic t_low_power;
      lp = 1'b1;
      tick(2);
      lp = 1'b0;
      wdog = 1'b1;
      tick(2);
      wdog = 1'b0;
      chk(sys_rst, 1'b1);
      chk(dom[0].clk_en, 1'b0);
      wait_for(1, n);
      chk(n < 200, 1'b1);
      chk(gate_en & cpu_clk_en, 1'b1);
      chk(lvds_en, 1'b0);
      lvds_req = 1'b1;
      tick(2);
      chk(lvds_en, 1'b0);
      init_done = 1'b1;
      tick(2);
      chk(lvds_en, 1'b1);
      lvds_req = 1'b0;
      init_done = 1'b0;
   endtask
   // Warning with acknowledge, then warning left to time out
   task automatic t_power_fail;
      droop = 1'b1;
      tick(3);
      chk(park & cpu_rst_b, 1'b1);
      parked = 1'b1;
      tick(2);
      parked = 1'b0;
      chk(park, 1'b0);
      chk(sys_rst & ~cpu_rst_b & pll_rst_b, 1'b1);
      droop = 1'b0;
      wait_for(1, n);
      chk(sys_rst, 1'b0);
      droop = 1'b1;
      tick(10);
      chk(park, 1'b1);
      tick(12);
      chk(sys_rst & ~park, 1'b1);
      droop = 1'b0;
   endtask
   // Reset during the power-fail warm-reset hold with sense high, no false edge, then sense drop from run
   task automatic t_mid_reset;
      i_rst_b = 1'b0;
      tick(2);
      chk(sys_rst & ~pll_rst_b & ~cpu_rst_b & ~pad_oe, 1'b1);
      chk(dom === '0 && !lvds_en && !park && !dram_init && !gate_en, 1'b1);
      i_rst_b = 1'b1;
      tick(4);
      chk(pll_rst_b | pad_oe, 1'b0);
      sup_up = 1'b0;
      tick(3);
      sup_up = 1'b1;
      wait_for(0, n);
      chk(pll_rst_b & ~cpu_rst_b, 1'b1);
      wait_for(1, n);
      chk(n == SC, 1'b1);
      sup_up = 1'b0;
      tick(3);
      chk(sys_rst & ~cpu_rst_b & ~pad_oe & ~pll_rst_b, 1'b1);
   endtask
   // ---------------------------------------------------------------
   // Main sequence and watchdog
   // ---------------------------------------------------------------
   initial begin
      tick(6);
      i_rst_b = 1'b1;
      t_off();
      t_power_up();
      t_boot();
      t_low_power();
      t_power_fail();
      t_mid_reset();
      give_verdict();
   end
   // Whole run is under two hundred cycles; allow over twenty-five times that
   initial begin
      #500_000;
      bad_count++;
      give_verdict();
   end
endmodule
`default_nettype wire
